// file: core/smsq_map.vh
/*
 * Register map, field positions, reset values and sensor codes of the
 * sensor monitor sequencer.
 * Assumes it is included by bare name by every core file that needs it.
 */
`ifndef SMSQ_MAP_VH
`define SMSQ_MAP_VH

////////////////////////////////////////////////////////////////////////
// register offsets
`define SMSQ_A_GAIN 9'h1e7
`define SMSQ_A_BSEL 9'h1e8
`define SMSQ_A_SEQ 9'h1e9
`define SMSQ_A_RDBK 9'h1ea
`define SMSQ_A_LOCK 9'h1ee
`define SMSQ_A_ST 9'h1f0
`define SMSQ_A_MSK 9'h1f1
`define SMSQ_A_CTL 9'h1f2

////////////////////////////////////////////////////////////////////////
// reset values
`define SMSQ_RST_GAIN 16'h0012
`define SMSQ_RST_BSEL 16'h0920
`define SMSQ_RST_SEQ 16'h036d
`define SMSQ_RST_RDBK 16'h0000
`define SMSQ_RST_LOCK 16'h0035
`define SMSQ_RST_CTL 16'h0000

////////////////////////////////////////////////////////////////////////
// fields
`define SMSQ_GAIN_HI 7
`define SMSQ_GAIN_LO 0
`define SMSQ_SEQ_GSRC 15
`define SMSQ_SEQ_BYP 14
`define SMSQ_SEQ_ITER_HI 13
`define SMSQ_SEQ_ITER_LO 12
`define SMSQ_SEQ_SLOT3_HI 11
`define SMSQ_SEQ_SLOT3_LO 9
`define SMSQ_SEQ_SLOT2_HI 8
`define SMSQ_SEQ_SLOT2_LO 6
`define SMSQ_SEQ_SLOT1_HI 5
`define SMSQ_SEQ_SLOT1_LO 3
`define SMSQ_SEQ_SLOT0_HI 2
`define SMSQ_SEQ_SLOT0_LO 0
`define SMSQ_BSEL_RSTLVL 15
`define SMSQ_BSEL_SEL_HI 2
`define SMSQ_BSEL_SEL_LO 0
`define SMSQ_LOCK_ECC_EN 8
`define SMSQ_LOCK_ERR_INJ 7
`define SMSQ_CTL_FORCE 0
`define SMSQ_ST_ECC 0
`define SMSQ_ST_FULL 1
`define SMSQ_ST_SAMPLE 2
`define SMSQ_ST_W 3

////////////////////////////////////////////////////////////////////////
// sensor codes and slot indices
`define SMSQ_SNS_ASUP_HIGH 3'h0
`define SMSQ_SNS_ASUP_MID 3'h1
`define SMSQ_SNS_CORE 3'h2
`define SMSQ_SNS_IO 3'h3
`define SMSQ_SNS_TEMP 3'h4
`define SMSQ_SNS_LAST 3'h4
`define SMSQ_SLOT_LAST 2'h3

`endif

// file: core/smsq_prot.v
/*
 * Checksum guard over the protected configuration words.
 * Assumes upd_i is high for the one cycle after any write to a guarded
 * word, so the stored code is refreshed from the new values.
 */
`include "smsq_map.vh"

module smsq_prot (
    input wire clk_i,
    input wire reset_n_i,
    input wire upd_i,
    input wire en_i,
    input wire inj_i,
    input wire [15:0] word0_i,
    input wire [15:0] word1_i,
    input wire [15:0] word2_i,
    output reg err_o
);

    function [15:0] fold;
        input [15:0] a;
        input [15:0] b;
        input [15:0] c;
        begin
            // rotations keep a swap of equal bits between words visible
            fold = a ^ {b[14:0], b[15]} ^ {c[13:0], c[15:14]};
        end
    endfunction

    // code of the reset contents, so the guard starts quiet
    localparam [15:0] RST_CODE = fold(`SMSQ_RST_GAIN, `SMSQ_RST_BSEL, `SMSQ_RST_SEQ);

    reg [15:0] code_q;
    wire [15:0] sum;
    wire [15:0] ref_code;

    assign sum = fold(word0_i, word1_i, word2_i);
    assign ref_code = code_q ^ {15'h0000, inj_i};

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            code_q <= RST_CODE;
            err_o <= 1'b0;
        end else begin
            if (upd_i)
                code_q <= sum;
            // mismatch masked while the code catches up with a write
            err_o <= en_i & ~upd_i & (ref_code != sum); // R10 R11
        end
    end

endmodule

// file: core/smsq_irq.v
/*
 * Sticky event status with write-one-to-clear, mask and level interrupt.
 * Assumes events are single-cycle pulses on the same clock.
 */
module smsq_irq #(
    parameter N = 3
) (
    input wire clk_i,
    input wire reset_n_i,
    input wire [N-1:0] ev_i,
    input wire wr_st_i,
    input wire wr_msk_i,
    input wire [N-1:0] wdata_i,
    output reg [N-1:0] st_o,
    output reg [N-1:0] msk_o,
    output reg irq_o
);

    reg [N-1:0] st_d;

    always @* begin
        st_d = st_o;
        if (wr_st_i)
            st_d = st_d & ~wdata_i;
        // an event in the clearing cycle survives
        st_d = st_d | ev_i;
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_o <= {N{1'b0}};
            msk_o <= {N{1'b0}};
            irq_o <= 1'b0;
        end else begin
            st_o <= st_d;
            if (wr_msk_i)
                msk_o <= wdata_i;
            irq_o <= |(st_d & (wr_msk_i ? wdata_i : msk_o));
        end
    end

endmodule

// file: core/smsq_top.v
/*
 * Sensor monitor sequencer: register bank, slot sequencer, bypass path,
 * gain source choice, readback capture, checksum guard and interrupt.
 * Assumes the sensor front end, fuse block and link status run on clk_i;
 * the front end answers each convert pulse with one sensor_done_i pulse.
 */
// The plain strobed port was decided locally.
// Overview of operation
// R1 - gain source bit 0 takes gain from fuses, 1 from the gain register field.
// R2 - bypass bit 0 lets the sequencer drive sensors, 1 hands selection to software fields.
// R3 - slots are cycled the iteration count of times, then all sensors are checked.
// R4 - slot 3 sensor is field bits 11 to 9, reset 1.
// R5 - slot 2 sensor is field bits 8 to 6, reset 5.
// R6 - slot 1 sensor is field bits 5 to 3, reset 5.
// R7 - slot 0 sensor is field bits 2 to 0, reset 5.
// R8 - sensor readback sits in a 16-bit read-only register that resets to zero.
// R9 - software reads one sensor by setting bypass and the bypass select first.
// R10 - the ECC enable bit turns on checksum protection of the configuration bank.
// R11 - with protection on, the injection bit forces an error in the bank.
// R12 - codes 0 to 4 are the five sensors and codes 5 to 7 are reserved.
// R13 - monitors start after link up unless force start enables them earlier.
// R14 - in bypass a control bit sets the sensor reset level, 0 held and 1 released.
// R15 - slots are visited in ascending order, one conversion each.
// R16 - a detected checksum error raises a status flag software can see.
`include "smsq_map.vh"

module smsq_top (
    input wire clk_i,
    input wire reset_n_i,
    input wire [8:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [15:0] rdata_o,
    input wire link_up_i,
    input wire [7:0] fuse_gain_i,
    input wire sensor_done_i,
    input wire [15:0] sensor_data_i,
    output reg [2:0] sensor_sel_o,
    output reg sensor_convert_o,
    output reg sensor_reset_n_o,
    output reg [7:0] sensor_gain_o,
    output wire irq_o
);

    // one-hot sequencer states
    localparam S_IDLE = 5'h01;
    localparam S_SLOT = 5'h02;
    localparam S_ALL = 5'h04;
    localparam S_BYP = 5'h08;
    localparam S_WAIT = 5'h10;

    ////////////////////////////////////////////////////////////////////
    // register bank

    reg [15:0] gain_q;
    reg [15:0] bsel_q;
    reg [15:0] seq_q;
    reg [15:0] lock_q;
    reg [15:0] ctl_q;
    reg [15:0] rdbk_q;
    reg upd_q;

    wire wr_gain;
    wire wr_bsel;
    wire wr_seq;
    wire wr_lock;
    wire wr_ctl;
    wire wr_st;
    wire wr_msk;
    wire ecc_err;
    wire [`SMSQ_ST_W-1:0] st;
    wire [`SMSQ_ST_W-1:0] msk;
    wire [`SMSQ_ST_W-1:0] ev;

    assign wr_gain = wr_i & (addr_i == `SMSQ_A_GAIN);
    assign wr_bsel = wr_i & (addr_i == `SMSQ_A_BSEL);
    assign wr_seq = wr_i & (addr_i == `SMSQ_A_SEQ);
    // readback offset has no write decode, so a stray write cannot hide a result
    assign wr_lock = wr_i & (addr_i == `SMSQ_A_LOCK);
    assign wr_ctl = wr_i & (addr_i == `SMSQ_A_CTL);
    assign wr_st = wr_i & (addr_i == `SMSQ_A_ST);
    assign wr_msk = wr_i & (addr_i == `SMSQ_A_MSK);

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gain_q <= `SMSQ_RST_GAIN;
            bsel_q <= `SMSQ_RST_BSEL;
            seq_q <= `SMSQ_RST_SEQ; // R4 R5 R6 R7
            lock_q <= `SMSQ_RST_LOCK;
            ctl_q <= `SMSQ_RST_CTL;
            upd_q <= 1'b0;
        end else begin
            if (wr_gain)
                gain_q <= wdata_i;
            if (wr_bsel)
                bsel_q <= wdata_i;
            if (wr_seq)
                seq_q <= wdata_i;
            if (wr_lock)
                lock_q <= wdata_i;
            if (wr_ctl)
                ctl_q <= wdata_i;
            upd_q <= wr_gain | wr_bsel | wr_seq;
        end
    end

    // read data valid only in the cycle after the strobe
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            // unmapped offsets read as zero
            case (addr_i)
                `SMSQ_A_GAIN: rdata_o <= gain_q;
                `SMSQ_A_BSEL: rdata_o <= bsel_q;
                `SMSQ_A_SEQ: rdata_o <= seq_q;
                `SMSQ_A_RDBK: rdata_o <= rdbk_q; // R8
                `SMSQ_A_LOCK: rdata_o <= lock_q;
                `SMSQ_A_ST: rdata_o <= {13'h0000, st};
                `SMSQ_A_MSK: rdata_o <= {13'h0000, msk};
                `SMSQ_A_CTL: rdata_o <= ctl_q;
                default: rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mode decode

    wire byp;
    wire mon_en;
    wire run;
    wire bgo;
    wire [1:0] iter_n;
    wire [2:0] bsel;

    assign byp = seq_q[`SMSQ_SEQ_BYP];
    assign mon_en = link_up_i | ctl_q[`SMSQ_CTL_FORCE]; // R13
    assign run = mon_en & ~byp; // R2
    // bypass converts only once software releases the sensor
    assign bgo = byp & bsel_q[`SMSQ_BSEL_RSTLVL]; // R14
    assign iter_n = seq_q[`SMSQ_SEQ_ITER_HI:`SMSQ_SEQ_ITER_LO];
    assign bsel = bsel_q[`SMSQ_BSEL_SEL_HI:`SMSQ_BSEL_SEL_LO];

    function [2:0] slot_code;
        input [15:0] seq;
        input [1:0] idx;
        begin
            case (idx)
                2'h0: slot_code = seq[`SMSQ_SEQ_SLOT0_HI:`SMSQ_SEQ_SLOT0_LO];
                2'h1: slot_code = seq[`SMSQ_SEQ_SLOT1_HI:`SMSQ_SEQ_SLOT1_LO];
                2'h2: slot_code = seq[`SMSQ_SEQ_SLOT2_HI:`SMSQ_SEQ_SLOT2_LO];
                default: slot_code = seq[`SMSQ_SEQ_SLOT3_HI:`SMSQ_SEQ_SLOT3_LO];
            endcase
        end
    endfunction

    // codes above the last sensor are reserved
    function sns_valid;
        input [2:0] code;
        begin
            sns_valid = (code <= `SMSQ_SNS_LAST);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // sequencer

    reg [4:0] st_q;
    reg [4:0] st_d;
    reg [4:0] ret_q;
    reg [4:0] ret_d;
    reg [1:0] slot_q;
    reg [1:0] slot_d;
    reg [1:0] iter_q;
    reg [1:0] iter_d;
    reg [2:0] all_q;
    reg [2:0] all_d;
    reg [2:0] sel_d;
    reg conv_d;
    reg full_ev;
    reg adv;
    reg [2:0] code;
    reg byp_path;

    always @* begin
        st_d = st_q;
        ret_d = ret_q;
        slot_d = slot_q;
        iter_d = iter_q;
        all_d = all_q;
        sel_d = sensor_sel_o;
        conv_d = 1'b0;
        full_ev = 1'b0;
        adv = 1'b0;
        code = slot_code(seq_q, slot_q);
        byp_path = (st_q == S_BYP) | ((st_q == S_WAIT) & (ret_q == S_BYP));
        case (st_q)
            S_IDLE: begin
                slot_d = 2'h0;
                iter_d = 2'h0;
                all_d = `SMSQ_SNS_ASUP_HIGH;
                if (bgo)
                    st_d = S_BYP;
                else if (run)
                    st_d = (iter_n == 2'h0) ? S_ALL : S_SLOT; // R3
            end
            S_SLOT: begin
                // reserved codes leave the slot empty
                if (sns_valid(code)) begin // R12
                    sel_d = code; // R15
                    conv_d = 1'b1;
                    ret_d = S_SLOT;
                    st_d = S_WAIT;
                end else begin
                    adv = 1'b1;
                end
            end
            S_ALL: begin
                sel_d = all_q;
                conv_d = 1'b1;
                ret_d = S_ALL;
                st_d = S_WAIT;
            end
            S_BYP: begin
                sel_d = bsel; // R2 R9
                if (sns_valid(bsel)) begin // R12
                    conv_d = 1'b1;
                    ret_d = S_BYP;
                    st_d = S_WAIT;
                end
            end
            S_WAIT: begin
                if (sensor_done_i) begin
                    if (ret_q == S_SLOT) begin
                        st_d = S_SLOT;
                        adv = 1'b1;
                    end else if (ret_q == S_ALL) begin
                        if (all_q == `SMSQ_SNS_LAST) begin
                            st_d = S_IDLE;
                            full_ev = 1'b1;
                        end else begin
                            all_d = all_q + 3'h1;
                            st_d = S_ALL;
                        end
                    end else begin
                        st_d = S_BYP;
                    end
                end
            end
            default: begin
                st_d = S_IDLE;
            end
        endcase
        if (adv) begin
            if (slot_q == `SMSQ_SLOT_LAST) begin
                slot_d = 2'h0;
                if ({1'b0, iter_q} + 3'h1 == {1'b0, iter_n}) begin // R3
                    iter_d = 2'h0;
                    st_d = S_ALL;
                end else begin
                    iter_d = iter_q + 2'h1;
                end
            end else begin
                slot_d = slot_q + 2'h1; // R15
            end
        end
        // a mode change abandons the pass in progress
        if (st_q != S_IDLE && (byp_path ? ~bgo : ~run)) begin
            st_d = S_IDLE;
            conv_d = 1'b0;
        end
    end

    // sel holds between conversions, except that bypass drives a reserved select code onto it without converting
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q <= S_IDLE;
            ret_q <= S_IDLE;
            slot_q <= 2'h0;
            iter_q <= 2'h0;
            all_q <= `SMSQ_SNS_ASUP_HIGH;
            sensor_sel_o <= `SMSQ_SNS_ASUP_HIGH;
            sensor_convert_o <= 1'b0;
        end else begin
            st_q <= st_d;
            ret_q <= ret_d;
            slot_q <= slot_d;
            iter_q <= iter_d;
            all_q <= all_d;
            sensor_sel_o <= sel_d;
            sensor_convert_o <= conv_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sensor reset, gain and readback

    // registered so every pin leaves a flop, at the cost of one cycle of lag
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sensor_reset_n_o <= 1'b0;
            sensor_gain_o <= 8'h00;
            rdbk_q <= `SMSQ_RST_RDBK;
        end else begin
            sensor_reset_n_o <= byp ? bsel_q[`SMSQ_BSEL_RSTLVL] : mon_en; // R13 R14
            sensor_gain_o <= seq_q[`SMSQ_SEQ_GSRC] ?
                gain_q[`SMSQ_GAIN_HI:`SMSQ_GAIN_LO] : fuse_gain_i; // R1
            if (sensor_done_i)
                rdbk_q <= sensor_data_i; // R8
        end
    end

    ////////////////////////////////////////////////////////////////////
    // protection and interrupt

    smsq_prot u_prot (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .upd_i(upd_q),
        .en_i(lock_q[`SMSQ_LOCK_ECC_EN]), // R10
        .inj_i(lock_q[`SMSQ_LOCK_ERR_INJ]), // R11
        .word0_i(gain_q),
        .word1_i(bsel_q),
        .word2_i(seq_q),
        .err_o(ecc_err)
    );

    // status bits: checksum error, full check done, sample taken
    assign ev = {sensor_done_i, full_ev, ecc_err}; // R16

    smsq_irq #(
        .N(`SMSQ_ST_W)
    ) u_irq (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ev_i(ev),
        .wr_st_i(wr_st),
        .wr_msk_i(wr_msk),
        .wdata_i(wdata_i[`SMSQ_ST_W-1:0]),
        .st_o(st),
        .msk_o(msk),
        .irq_o(irq_o)
    );

endmodule

// file: tb/smsq_assertions.sv
/* Port checker of smsq_top: register shadows and timing relations.
   Assumes a bind to smsq_top; shadows take writes at the same edge as the design. */
module smsq_chk (
    input wire clk_i,
    input wire reset_n_i,
    input wire [8:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [15:0] rdata_o,
    input wire link_up_i,
    input wire [7:0] fuse_gain_i,
    input wire sensor_done_i,
    input wire [15:0] sensor_data_i,
    input wire [2:0] sensor_sel_o,
    input wire sensor_convert_o,
    input wire sensor_reset_n_o,
    input wire [7:0] sensor_gain_o,
    input wire irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [15:0] seq_q, bsel_q, rdbk_q;
    reg [7:0] gain_q;
    reg [2:0] msk_q;
    reg frc_q;
    reg [1:0] up_q;
    wire [7:0] gain_x = seq_q[15] ? gain_q : fuse_gain_i;
    wire lvl_x = seq_q[14] ? bsel_q[15] : (link_up_i | frc_q);
    ////////////////////////////////////////////////////////////////////
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            seq_q <= 16'h036d;
            bsel_q <= 16'h0920;
            gain_q <= 8'h12;
            msk_q <= 3'h0;
            frc_q <= 1'b0;
            rdbk_q <= 16'h0000;
            up_q <= 2'h0;
        end else begin
            if (wr_i && addr_i == 9'h1e9) seq_q <= wdata_i;
            if (wr_i && addr_i == 9'h1e8) bsel_q <= wdata_i;
            if (wr_i && addr_i == 9'h1e7) gain_q <= wdata_i[7:0];
            if (wr_i && addr_i == 9'h1f1) msk_q <= wdata_i[2:0];
            if (wr_i && addr_i == 9'h1f2) frc_q <= wdata_i[0];
            if (sensor_done_i) rdbk_q <= sensor_data_i;
            // outputs lag a cycle, so skip the edges where $past sees reset
            if (up_q != 2'h3) up_q <= up_q + 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    rd_idle_a: assert property (!rd_i |=> rdata_o == 16'h0000)
        else $error("read data not zero outside a read");
    rd_back_a: assert property (rd_i && addr_i == 9'h1ea |=> rdata_o == $past(rdbk_q))
        else $error("readback not last sensor result");
    conv_one_a: assert property (sensor_convert_o |=> !sensor_convert_o)
        else $error("convert longer than one cycle");
    conv_code_a: assert property (sensor_convert_o |-> sensor_sel_o <= 3'h4)
        else $error("conversion of a reserved code");
    gain_src_a: assert property (up_q == 2'h3 |-> sensor_gain_o == $past(gain_x))
        else $error("gain from wrong source");
    rst_lvl_a: assert property (up_q == 2'h3 |-> sensor_reset_n_o == $past(lvl_x))
        else $error("sensor reset level wrong");
    byp_sel_a: assert property (sensor_convert_o && seq_q[14] && $past(seq_q[14]) && $stable(bsel_q)
        |-> sensor_sel_o == bsel_q[2:0])
        else $error("bypass converts wrong sensor");
    irq_mask_a: assert property (msk_q == 3'h0 && $past(msk_q) == 3'h0 |-> !irq_o)
        else $error("interrupt while all masked");
    ecc_irq_a: assert property (wr_i && addr_i == 9'h1ee && wdata_i[8:7] == 2'b11 && msk_q[0]
        |-> ##[1:6] irq_o)
        else $error("injected error not flagged");
    cover property (sensor_convert_o && sensor_sel_o == 3'h4);
    cover property (sensor_done_i && seq_q[14]);
    cover property ($rose(irq_o));
endmodule

bind smsq_top smsq_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link_up_i(link_up_i),
    .fuse_gain_i(fuse_gain_i), .sensor_done_i(sensor_done_i), .sensor_data_i(sensor_data_i),
    .sensor_sel_o(sensor_sel_o), .sensor_convert_o(sensor_convert_o),
    .sensor_reset_n_o(sensor_reset_n_o), .sensor_gain_o(sensor_gain_o), .irq_o(irq_o));

// file: tb/tb_smsq_top.sv
/* Self-checking bench of the sensor monitor sequencer.
   Assumes smsq_top and its bound checker are compiled before it. */
module tb_smsq_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, reset_n_i, wr_i, rd_i, link_up_i, sensor_done_i;
    logic [8:0] addr_i;
    logic [15:0] wdata_i, sensor_data_i;
    logic [7:0] fuse_gain_i;
    wire [15:0] rdata_o;
    wire [2:0] sensor_sel_o;
    wire [7:0] sensor_gain_o;
    wire sensor_convert_o, sensor_reset_n_o, irq_o;
    int fail_count, samples_checked, cyc, n, i;
    logic [2:0] seen[$];
    logic [2:0] ord[9] = '{3'h3, 3'h1, 3'h3, 3'h1, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4};

    smsq_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link_up_i(link_up_i),
        .fuse_gain_i(fuse_gain_i), .sensor_done_i(sensor_done_i), .sensor_data_i(sensor_data_i),
        .sensor_sel_o(sensor_sel_o), .sensor_convert_o(sensor_convert_o),
        .sensor_reset_n_o(sensor_reset_n_o), .sensor_gain_o(sensor_gain_o), .irq_o(irq_o));
    ////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
        samples_checked++;
        if (got !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, e, got);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, input logic [15:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(posedge clk_i);
        chk($sformatf("reg %h", a), e, rdata_o);
    endtask
    task automatic wseen(input int cnt);
        int k;
        for (k = 0; k < 3000 && seen.size() < cnt; k++) @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 6000) begin
            fail_count++;
            end_sim();
        end
    end
    // front end stand-in: one result per convert, a little late on purpose
    initial begin
        sensor_done_i = 1'b0;
        sensor_data_i = 16'h0000;
        forever begin
            @(posedge clk_i);
            if (sensor_convert_o === 1'b1) begin
                seen.push_back(sensor_sel_o);
                repeat (2) @(posedge clk_i);
                sensor_done_i <= 1'b1;
                sensor_data_i <= {13'h1500, seen[$]};
                @(posedge clk_i);
                sensor_done_i <= 1'b0;
            end
        end
    end
    initial begin
        reset_n_i = 1'b0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 9'h000;
        wdata_i = 16'h0000;
        link_up_i = 1'b0;
        fuse_gain_i = 8'h5a;
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd(9'h1e9, 16'h036d);
        rd(9'h1ea, 16'h0000);
        rd(9'h1ee, 16'h0035);
        wr(9'h1ea, 16'hffff);
        wr(9'h100, 16'hffff);
        rd(9'h100, 16'h0000);
        rd(9'h1ea, 16'h0000);
        chk("gain", 16'h005a, {8'h00, sensor_gain_o});
        chk("sensor reset", 16'h0000, {15'h0, sensor_reset_n_o});
        wr(9'h1e7, 16'h00c3);
        wr(9'h1e9, 16'ha2ed);
        wr(9'h1f1, 16'h0002);
        wr(9'h1f2, 16'h0001);
        // tenth convert opens the next pass, so the full check has ended
        wseen(10);
        chk("sensor reset", 16'h0001, {15'h0, sensor_reset_n_o});
        chk("gain", 16'h00c3, {8'h00, sensor_gain_o});
        for (i = 0; i < 9; i++) chk("slot order", {13'h0, ord[i]}, {13'h0, seen[i]});
        wr(9'h1f2, 16'h0000);
        repeat (8) @(posedge clk_i);
        chk("irq", 16'h0001, {15'h0, irq_o});
        rd(9'h1f0, 16'h0006);
        wr(9'h1f0, 16'h0006);
        rd(9'h1f0, 16'h0000);
        chk("irq", 16'h0000, {15'h0, irq_o});
        // bypass: software picks the sensor and its reset level
        wr(9'h1e8, 16'h8004);
        wr(9'h1e9, 16'h4000);
        n = seen.size();
        wseen(n + 2);
        chk("bypass sensor", 16'h0004, {13'h0, seen[n]});
        chk("sensor reset", 16'h0001, {15'h0, sensor_reset_n_o});
        chk("gain", 16'h005a, {8'h00, sensor_gain_o});
        rd(9'h1ea, {13'h1500, 3'h4});
        wr(9'h1e8, 16'h8007);
        repeat (6) @(posedge clk_i);
        n = seen.size();
        repeat (20) @(posedge clk_i);
        chk("reserved convert", n[15:0], seen.size());
        wr(9'h1e8, 16'h0004);
        repeat (2) @(posedge clk_i);
        chk("sensor reset", 16'h0000, {15'h0, sensor_reset_n_o});
        wr(9'h1e9, 16'h036d);
        // protection on, then a deliberate error
        wr(9'h1f1, 16'h0001);
        wr(9'h1ee, 16'h0135);
        repeat (6) @(posedge clk_i);
        chk("irq", 16'h0000, {15'h0, irq_o});
        wr(9'h1ee, 16'h01b5);
        repeat (6) @(posedge clk_i);
        chk("irq", 16'h0001, {15'h0, irq_o});
        // sample bit still stands from the bypass conversions
        rd(9'h1f0, 16'h0005);
        wr(9'h1ee, 16'h0135);
        repeat (4) @(posedge clk_i);
        wr(9'h1f0, 16'h0007);
        rd(9'h1f0, 16'h0000);
        chk("irq", 16'h0000, {15'h0, irq_o});
        // link up alone starts the monitors; count 0 goes straight to the full check
        link_up_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("sensor reset", 16'h0001, {15'h0, sensor_reset_n_o});
        n = seen.size();
        wseen(n + 1);
        chk("full check start", 16'h0000, {13'h0, seen[n]});
        end_sim();
    end
endmodule
